//--- logic/hcc_params.svh
// Purpose: constants of the horizontal clock edge core
// Assumes: included by the package only; the core uses its macros without including it
// Notes: offsets are serial-port addresses
`ifndef HCC_PARAMS_SVH
`define HCC_PARAMS_SVH
`define HCC_ADDR_W 8
`define HCC_DATA_W 24
`define HCC_FRAME_BITS 6'h20
`define HCC_OFS_CORE_RST 8'h15
`define HCC_OFS_UPDATE_LINE 8'h18
`define HCC_OFS_CLK_DIV 8'h30
`define HCC_OFS_PH12 8'h31
`define HCC_OFS_PH34 8'h32
`define HCC_OFS_LAST 8'h33
`define HCC_OFS_RGATE 8'h34
`define HCC_OFS_BLANK 8'h35
`define HCC_OFS_DRIVE 8'h36
`define HCC_EDGE_RESET 17'h11400
`define HCC_RGATE_RESET 17'h10a00
`define HCC_DRIVE_RESET 24'h111111
`define HCC_STEPS_MAX 6'h3f
`endif

//--- logic/hcc_pkg.sv
// Purpose: types of the horizontal clock edge core
// Assumes: hcc_params.svh holds the numbers
// Notes: edge register layout packed as written on the serial port
package hcc_pkg;
  `include "hcc_params.svh"
  typedef struct packed {
    logic polarity;
    logic [1:0] pad_hi;
    logic [5:0] fall_pos;
    logic [1:0] pad_lo;
    logic [5:0] rise_pos;
  } hcc_edge_t;
  typedef struct packed {
    logic [2:0] widening;
    logic last_stage_blank_enable;
    logic last_stage_blank_retime;
    logic phase_three_four_blank_retime;
    logic phase_one_two_blank_retime;
  } hcc_blank_t;
  typedef struct packed {
    logic horiz_phase_one_clock;
    logic horiz_phase_two_clock;
    logic horiz_phase_three_clock;
    logic horiz_phase_four_clock;
    logic last_stage_horiz_clock;
    logic reset_gate_clock;
  } hcc_clocks_t;
endpackage

//--- logic/hcc_core.sv
// Purpose: horizontal ccd clock edge generator with serial register port
// Assumes: sys_clk is the master clock input; serial pins and syncs are asynchronous
// Notes: serial frame is 8 address bits then 24 data bits, lsb first, while load is low
`timescale 1ns/1ns
module hcc_core
  import hcc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic serial_clock,
  input wire logic serial_data,
  input wire logic serial_load_n,
  input wire logic vertical_sync,
  input wire logic horiz_sync,
  input wire logic horiz_blanking_window,
  output hcc_clocks_t ccd_clocks,
  output logic [23:0] drive_strength
);
  // ==========================================================
  // input synchronisers
  logic [1:0] sck_s_q, sda_s_q, sld_s_q, vd_s_q, hd_s_q, hb_s_q;
  logic sck_prev_q, sld_prev_q, vd_prev_q, hd_prev_q;

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sck_s_q <= 2'h0;
      sda_s_q <= 2'h0;
      sld_s_q <= 2'h3;
      vd_s_q <= 2'h0;
      hd_s_q <= 2'h0;
      hb_s_q <= 2'h0;
      sck_prev_q <= 1'h0;
      sld_prev_q <= 1'h1;
      vd_prev_q <= 1'h0;
      hd_prev_q <= 1'h0;
    end
    else
    begin
      sck_s_q <= {sck_s_q[0], serial_clock};
      sda_s_q <= {sda_s_q[0], serial_data};
      sld_s_q <= {sld_s_q[0], serial_load_n};
      vd_s_q <= {vd_s_q[0], vertical_sync};
      hd_s_q <= {hd_s_q[0], horiz_sync};
      hb_s_q <= {hb_s_q[0], horiz_blanking_window};
      sck_prev_q <= sck_s_q[1];
      sld_prev_q <= sld_s_q[1];
      vd_prev_q <= vd_s_q[1];
      hd_prev_q <= hd_s_q[1];
    end
  end

  logic sck_rise, load_end, vd_rise, hd_rise, blank_in;
  assign sck_rise = sck_s_q[1] & ~sck_prev_q;
  assign load_end = sld_s_q[1] & ~sld_prev_q;
  assign vd_rise = vd_s_q[1] & ~vd_prev_q;
  assign hd_rise = hd_s_q[1] & ~hd_prev_q;
  assign blank_in = hb_s_q[1];

  // ==========================================================
  // serial write port
  logic [31:0] shift_q;
  logic [5:0] bit_cnt_q;

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      shift_q <= 32'h0;
      bit_cnt_q <= 6'h0;
    end
    else if (sld_s_q[1])
      bit_cnt_q <= 6'h0;
    else if (sck_rise)
    begin
      shift_q <= {sda_s_q[1], shift_q[31:1]};
      // extra clocks past a full frame still shift the data; only the count stops at 32
      if (bit_cnt_q != `HCC_FRAME_BITS)
        bit_cnt_q <= bit_cnt_q + 6'h1;
    end
  end

  logic wr_en;
  logic [7:0] wr_addr;
  logic [23:0] wr_data;
  assign wr_en = load_end && (bit_cnt_q == `HCC_FRAME_BITS);
  assign wr_addr = shift_q[7:0];
  assign wr_data = shift_q[31:8];

  // ==========================================================
  // immediate registers
  logic core_release_q, halving_q;
  logic [11:0] update_line_q;
  hcc_edge_t ph12_q, ph34_q, last_q, rgate_q;
  hcc_blank_t blank_pend_q, blank_q;

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      core_release_q <= 1'h0;
      halving_q <= 1'h0;
      update_line_q <= 12'h0;
      ph12_q <= `HCC_EDGE_RESET;
      ph34_q <= `HCC_EDGE_RESET;
      last_q <= `HCC_EDGE_RESET;
      rgate_q <= `HCC_RGATE_RESET;
      blank_pend_q <= 7'h0;
      drive_strength <= `HCC_DRIVE_RESET;
    end
    else if (wr_en)
    begin
      unique case (wr_addr)
        `HCC_OFS_CORE_RST: core_release_q <= wr_data[0];
        `HCC_OFS_UPDATE_LINE: update_line_q <= wr_data[11:0];
        `HCC_OFS_CLK_DIV: halving_q <= wr_data[0];
        `HCC_OFS_PH12: ph12_q <= wr_data[16:0];
        `HCC_OFS_PH34: ph34_q <= wr_data[16:0];
        `HCC_OFS_LAST: last_q <= wr_data[16:0];
        `HCC_OFS_RGATE: rgate_q <= wr_data[16:0];
        `HCC_OFS_BLANK: blank_pend_q <= wr_data[6:0];
        `HCC_OFS_DRIVE: drive_strength <= wr_data;
        default: ;
      endcase
    end
  end

  // ==========================================================
  // frame-synchronised update of blanking control
  logic [11:0] line_q;

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      line_q <= 12'h0;
    else if (vd_rise)
      line_q <= 12'h0;
    else if (hd_rise)
      line_q <= line_q + 12'h1;
  end

  // blanking control waits for update point
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      blank_q <= 7'h0;
    else if (hd_rise && (line_q == update_line_q))
      blank_q <= blank_pend_q;
  end

  // ==========================================================
  // step counter within the pixel period
  logic half_q, tick;
  logic [5:0] step_q;

  // every other master edge when halving
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      half_q <= 1'h0;
    else if (!core_release_q)
      half_q <= 1'h0;
    else
      half_q <= ~half_q;
  end
  assign tick = core_release_q && (!halving_q || half_q);

  // counter held at zero while core is in reset
  // one step per tick, 64 steps per pixel
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      step_q <= 6'h0;
    else if (!core_release_q)
      step_q <= 6'h0;
    else if (tick)
      step_q <= step_q + 6'h1;
  end

  logic pixel_end;
  assign pixel_end = tick && (step_q == `HCC_STEPS_MAX);

  // ==========================================================
  // edge levels, blanking retime and widening
  function automatic logic edge_level(input hcc_edge_t e, input logic [5:0] s, input logic cur);
    if (s == e.rise_pos)
      edge_level = 1'h1;
    else if (s == e.fall_pos)
      edge_level = 1'h0;
    else
      edge_level = cur;
  endfunction

  logic lv12_q, lv34_q, lvl_q, lvrg_q;
  logic rt12_q, rt34_q, rtl_q;
  logic [2:0] wide_cnt_q;
  logic slow_q;

  // toggle at programmed steps each pixel
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      lv12_q <= 1'h0;
      lv34_q <= 1'h0;
      lvl_q <= 1'h0;
      lvrg_q <= 1'h0;
    end
    else if (!core_release_q)
    begin
      lv12_q <= 1'h0;
      lv34_q <= 1'h0;
      lvl_q <= 1'h0;
      lvrg_q <= 1'h0;
    end
    else if (tick)
    begin
      lv12_q <= edge_level(ph12_q, step_q, lv12_q);
      lv34_q <= edge_level(ph34_q, step_q, lv34_q);
      lvl_q <= edge_level(last_q, step_q, lvl_q);
      lvrg_q <= edge_level(rgate_q, step_q, lvrg_q);
    end
  end

  // captured at each group's rising step: one pixel of added delay
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rt12_q <= 1'h0;
      rt34_q <= 1'h0;
      rtl_q <= 1'h0;
    end
    else if (tick)
    begin
      if (step_q == ph12_q.rise_pos)
        rt12_q <= blank_in;
      if (step_q == ph34_q.rise_pos)
        rt34_q <= blank_in;
      if (step_q == last_q.rise_pos)
        rtl_q <= blank_in;
    end
  end

  logic blk12, blk34, blkl;
  assign blk12 = blank_q.phase_one_two_blank_retime ? rt12_q : blank_in;
  assign blk34 = blank_q.phase_three_four_blank_retime ? rt34_q : blank_in;
  assign blkl = blank_q.last_stage_blank_retime ? rtl_q : blank_in;

  // slow toggle every n pixels in blanking
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wide_cnt_q <= 3'h0;
      slow_q <= 1'h0;
    end
    else if (!(blk12 || blk34))
    begin
      wide_cnt_q <= 3'h0;
      slow_q <= lv12_q;
    end
    else if (pixel_end)
    begin
      if (wide_cnt_q + 3'h1 >= blank_q.widening)
      begin
        wide_cnt_q <= 3'h0;
        slow_q <= ~slow_q;
      end
      else
        wide_cnt_q <= wide_cnt_q + 3'h1;
    end
  end

  logic wide_on, raw12, raw34, rawl;
  assign wide_on = blank_q.widening != 3'h0;
  // slow level follows phase one; phase three takes its complement
  assign raw12 = (blk12 && wide_on) ? slow_q : lv12_q;
  assign raw34 = (blk34 && wide_on) ? ~slow_q : lv34_q;
  // last stage held low only when enabled
  assign rawl = (blkl && blank_q.last_stage_blank_enable) ? 1'h0 : lvl_q;

  // ==========================================================
  // registered outputs with polarity
  // polarity zero inverts the group
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      ccd_clocks <= 6'h0;
    else
    begin
      ccd_clocks.horiz_phase_one_clock <= raw12 ~^ ph12_q.polarity;
      ccd_clocks.horiz_phase_two_clock <= raw12 ^ ph12_q.polarity;
      ccd_clocks.horiz_phase_three_clock <= raw34 ~^ ph34_q.polarity;
      ccd_clocks.horiz_phase_four_clock <= raw34 ^ ph34_q.polarity;
      ccd_clocks.last_stage_horiz_clock <= rawl ~^ last_q.polarity;
      ccd_clocks.reset_gate_clock <= lvrg_q ~^ rgate_q.polarity;
    end
  end
endmodule

//--- testbench/hcc_sensor_model.sv
// Purpose: sensor side of the horizontal clocks, counts dumped pixels
// Assumes: clocks are sampled on the master clock
// Notes: behavioural, never drives back into the core
`timescale 1ns/1ns
module hcc_sensor_model
  import hcc_pkg::*;
(
  input wire logic sys_clk,
  input hcc_clocks_t ccd_clocks,
  output int pixels_dumped
);
  // ==========
  // charge dump on each last-stage rise
  logic last_q = 1'b0;
  initial pixels_dumped = 0;
  always @(posedge sys_clk)
  begin
    if (ccd_clocks.last_stage_horiz_clock === 1'b1 && last_q === 1'b0)
      pixels_dumped++;
    last_q <= ccd_clocks.last_stage_horiz_clock;
  end
endmodule

//--- testbench/hcc_core_assertions.sv
// Purpose: port-level checks of the horizontal clock core
// Assumes: bound to hcc_core
// Notes: register state is not visible, so checks tie outputs to frames and pairs
`timescale 1ns/1ns
module hcc_core_assertions
  import hcc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic serial_load_n,
  input hcc_clocks_t ccd_clocks,
  input wire logic [23:0] drive_strength
);
  // ==========
  // helper state
  logic load_q, frame_q, one_q, three_q;
  logic [7:0] gap_q;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      load_q <= 1'b1;
      frame_q <= 1'b0;
      one_q <= 1'b0;
      three_q <= 1'b0;
    end
    else
    begin
      load_q <= serial_load_n;
      frame_q <= frame_q | (serial_load_n & ~load_q);
      one_q <= one_q | ccd_clocks.horiz_phase_one_clock;
      three_q <= three_q | ccd_clocks.horiz_phase_three_clock;
    end
  end
  // saturating, so the first rise after reset passes
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      gap_q <= 8'hff;
    else if ($rose(ccd_clocks.reset_gate_clock))
      gap_q <= 8'h00;
    else if (gap_q != 8'hff)
      gap_q <= gap_q + 8'h01;
  end
  chk_reset_idle: assert property ($fell(sys_rst) |-> ccd_clocks == 6'h00)
    else $error("clocks active right after reset");
  chk_drive_default: assert property ($fell(sys_rst) |-> drive_strength == 24'h111111)
    else $error("drive copy not at reset value");
  // held core: phase two and four sit high as complements of phase one and three
  chk_idle_unreleased: assert property (!frame_q && !$past(sys_rst) |-> ccd_clocks == 6'h14)
    else $error("clocks run before any frame");
  chk_drive_by_frame: assert property ($changed(drive_strength)
    |-> $past(serial_load_n, 2) && !$past(serial_load_n, 6))
    else $error("drive copy changed away from a frame end");
  chk_pair_one_two: assert property (one_q
    |-> ccd_clocks.horiz_phase_two_clock != ccd_clocks.horiz_phase_one_clock)
    else $error("phase two not complement of phase one");
  chk_pair_three_four: assert property (three_q
    |-> ccd_clocks.horiz_phase_four_clock != ccd_clocks.horiz_phase_three_clock)
    else $error("phase four not complement of phase three");
  chk_rgate_held: assert property ($rose(ccd_clocks.reset_gate_clock) |=> ccd_clocks.reset_gate_clock)
    else $error("reset gate pulse of one cycle");
  chk_rgate_spacing: assert property ($rose(ccd_clocks.reset_gate_clock) |-> gap_q >= 8'd63)
    else $error("reset gate rises twice in one pixel");
  cover property ($rose(ccd_clocks.horiz_phase_one_clock));
  cover property ($rose(ccd_clocks.last_stage_horiz_clock));
  cover property ($changed(drive_strength));
endmodule
bind hcc_core hcc_core_assertions i_chk (.sys_clk, .sys_rst, .serial_load_n, .ccd_clocks, .drive_strength);

//--- testbench/test_horizontal_ccd_clock_edge_config.sv
// Purpose: self-checking bench of the horizontal clock core
// Assumes: 125 MHz master clock, serial frames of 8 address and 24 data bits
// Notes: pulse widths are measured in master clock cycles
`timescale 1ns/1ns
module test_horizontal_ccd_clock_edge_config;
  import hcc_pkg::*;
  logic sys_clk, sys_rst, serial_clock, serial_data, serial_load_n;
  logic vertical_sync, horiz_sync, horiz_blanking_window, busy;
  hcc_clocks_t ccd_clocks;
  logic [23:0] drive_strength, d;
  logic [23:0] exp_q[$];
  int err_total = 0, compares = 0, sel, w, k, pixels, base;
  logic [2:0] n;
  event go;
  hcc_core i_dut (.sys_clk, .sys_rst, .serial_clock, .serial_data, .serial_load_n, .vertical_sync,
    .horiz_sync, .horiz_blanking_window, .ccd_clocks, .drive_strength);
  hcc_sensor_model i_sensor (.sys_clk, .ccd_clocks, .pixels_dumped(pixels));
  always #4 sys_clk = ~sys_clk;
  // ==========
  // tasks
  task report_and_stop;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task chk(input logic [23:0] got);
    logic [23:0] e;
    e = exp_q.pop_front();
    compares++;
    if (got !== e)
    begin
      err_total++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, e);
    end
  endtask
  task send(input logic [7:0] a, input logic [23:0] v);
    logic [31:0] f;
    f = {v, a};
    serial_load_n = 1'b0;
    for (int i = 0; i < 32; i++)
    begin
      serial_data = f[i];
      repeat (4) @(negedge sys_clk);
      serial_clock = 1'b1;
      repeat (4) @(negedge sys_clk);
      serial_clock = 1'b0;
    end
    serial_load_n = 1'b1;
    repeat (8) @(negedge sys_clk);
  endtask
  task meas(input int b, input int e);
    exp_q.push_back(24'(e));
    sel = b;
    busy = 1'b1;
    ->go;
    wait (busy == 1'b0);
    @(negedge sys_clk);
  endtask
  task pulse_sync(input int which);
    if (which == 0) vertical_sync = 1'b1; else horiz_sync = 1'b1;
    repeat (4) @(negedge sys_clk);
    vertical_sync = 1'b0;
    horiz_sync = 1'b0;
    repeat (4) @(negedge sys_clk);
  endtask
  // ==========
  // monitor: width of next high run, 0 when none comes
  always @(drive_strength)
    if (sys_rst === 1'b0) chk(drive_strength);
  initial forever
  begin
    @go;
    k = 0;
    w = 0;
    // sampled mid-cycle, away from the edge that launches the outputs
    while (ccd_clocks[sel] !== 1'b0 && k < 2000) begin @(negedge sys_clk); k++; end
    while (ccd_clocks[sel] !== 1'b1 && k < 2000) begin @(negedge sys_clk); k++; end
    while (ccd_clocks[sel] === 1'b1 && k < 2000) begin @(negedge sys_clk); k++; w++; end
    chk(24'(w));
    busy = 1'b0;
  end
  initial
  begin
    #480000;
    err_total++;
    report_and_stop;
  end
  // ==========
  // main sequence
  initial
  begin
    {sys_clk, serial_clock, serial_data, vertical_sync, horiz_sync, horiz_blanking_window, busy} = 7'h00;
    sys_rst = 1'b1;
    serial_load_n = 1'b1;
    void'($urandom(32'hf5f0aed6));
    repeat (20) @(negedge sys_clk);
    sys_rst = 1'b0;
    exp_q.push_back(24'h111111);
    chk(drive_strength);
    meas(5, 0);
    send(8'h15, 24'h000001);
    meas(5, 20);
    meas(3, 20);
    meas(1, 20);
    // one last-stage rise per 64-cycle pixel
    base = pixels;
    repeat (640) @(negedge sys_clk);
    compares++;
    if (pixels - base != 10)
    begin
      err_total++;
      $display("MISMATCH t=%0t dumps %0d expected 10", $time, pixels - base);
    end
    meas(0, 10);
    send(8'h31, 24'h011e04);
    meas(5, 26);
    send(8'h34, 24'h011e00);
    meas(0, 30);
    send(8'h31, 24'h001e04);
    meas(5, 38);
    send(8'h30, 24'h000001);
    meas(5, 76);
    send(8'h30, 24'h000000);
    meas(5, 38);
    // top bit set so the write always changes the reset copy
    d = 24'($urandom) | 24'h800000;
    send(8'h3f, ~d);
    exp_q.push_back(d);
    send(8'h36, d);
    n = 3'($urandom % 7 + 1);
    horiz_blanking_window = 1'b1;
    send(8'h35, {17'h0, n, 4'h8});
    meas(5, 38);
    meas(1, 20);
    pulse_sync(0);
    pulse_sync(1);
    repeat (200) @(negedge sys_clk);
    meas(5, 64 * n);
    meas(1, 0);
    // update on line 2: third line start after the frame sync
    send(8'h18, 24'h000002);
    send(8'h35, 24'h000000);
    pulse_sync(0);
    pulse_sync(1);
    pulse_sync(1);
    meas(1, 0);
    pulse_sync(1);
    meas(1, 20);
    meas(5, 38);
    report_and_stop;
  end
endmodule
